// >>> logic/e1t_pkg.sv
// Constants, types and helpers for the E1 transmit pin interface
// Functional notes
// - Formatter runs on 2.048 MHz primary clock
// - Serial data sampled on selected clock falling
// - Channel clock high during each channel LSB
// - Channel block programmable per each channel
// - Link demand clock requests spare-bit data
// - Link bits sampled, inserted into chosen Sa
// - Control bit makes sync pin an input
// - Output sync is frame or multiframe pulse
// - Backplane boundary pulse aligns with store on
// - Signaling input sampled on selected falling edge
// - Elastic output updates on primary rising edge
// - Formatter data sampled on primary falling edge
// - Bipolar outputs update on formatter clock rise
// - Control bit selects NRZ on positive output
// - Formatter clock output copies primary clock
// - Line inputs sampled on line clock falling
// - Connect pin loops formatter into line inputs
// - Bit one is MSB, sent first
// - Timeslot zero is sent first
package e1t_pkg;
  localparam int BIT_W  = 3;
  localparam int CH_W   = 5;
  localparam int FR_W   = 4;
  localparam int POS_W  = BIT_W + CH_W + FR_W;
  localparam int ES_AW  = BIT_W + CH_W + 1;
  localparam int ES_DEPTH = 1 << ES_AW;
  localparam int NCH    = 32;
  localparam int SA_N   = 5;
  localparam int LSH_W  = 8;
  localparam int DW     = 32;
  localparam int BE_W   = 4;
  localparam int BYTE_W = 8;
  localparam int AV_AW  = 4;

  localparam logic [BIT_W-1:0] MSB_BIT  = 3'h0;
  localparam logic [BIT_W-1:0] LSB_BIT  = 3'h7;
  localparam logic [BIT_W-1:0] SA4_BIT  = 3'h3;
  localparam logic [CH_W-1:0]  FAS_SLOT = 5'h00;
  localparam logic [CH_W-1:0]  SIG_SLOT = 5'h10;
  localparam logic [FR_W-1:0]  MF_START = 4'h0;
  localparam logic [7:0]       FAS_BYTE = 8'h9B;

  // Register byte offsets
  localparam logic [AV_AW-1:0] OFS_CTRL  = 4'h0;
  localparam logic [AV_AW-1:0] OFS_CHBLK = 4'h4;
  localparam logic [AV_AW-1:0] OFS_STAT  = 4'h8;
  localparam logic [AV_AW-1:0] OFS_LINE  = 4'hC;

  // Control register fields
  localparam int C_SYNC_IN = 0;
  localparam int C_SYNC_MF = 1;
  localparam int C_NRZ     = 2;
  localparam int C_ES      = 3;
  localparam int C_LINK    = 4;
  localparam int C_SIG     = 5;
  localparam int C_SA      = 8;
  localparam logic [DW-1:0]  CTRL_RST  = 32'h0000_0000;
  localparam logic [NCH-1:0] CHBLK_RST = 32'h0000_0000;

  // Pin synchroniser slots
  localparam int P_PCLK  = 0;
  localparam int P_BCLK  = 1;
  localparam int P_LCLK  = 2;
  localparam int P_SER   = 3;
  localparam int P_SIG   = 4;
  localparam int P_LINK  = 5;
  localparam int P_FDAT  = 6;
  localparam int P_LPOS  = 7;
  localparam int P_LNEG  = 8;
  localparam int P_SYNC  = 9;
  localparam int P_BSYNC = 10;
  localparam int P_CONN  = 11;
  localparam int NPIN    = 12;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } e1t_bus_t;

  function automatic logic [BIT_W-1:0] pos_bit(input logic [POS_W-1:0] p);
    pos_bit = p[BIT_W-1:0];
  endfunction : pos_bit

  function automatic logic [CH_W-1:0] pos_ch(input logic [POS_W-1:0] p);
    pos_ch = p[BIT_W+CH_W-1:BIT_W];
  endfunction : pos_ch

  function automatic logic [FR_W-1:0] pos_fr(input logic [POS_W-1:0] p);
    pos_fr = p[POS_W-1:BIT_W+CH_W];
  endfunction : pos_fr

  // Odd frames carry the spare bits, even frames the alignment word
  function automatic logic sa_hit(input logic [POS_W-1:0] p, input logic [SA_N-1:0] sel);
    logic [BIT_W-1:0] k;
    k = pos_bit(p) - SA4_BIT;
    sa_hit = (pos_ch(p) == FAS_SLOT) && p[BIT_W+CH_W] && (pos_bit(p) >= SA4_BIT) && sel[k];
  endfunction : sa_hit

  function automatic logic [POS_W-1:0] frame_start(input logic [POS_W-1:0] p,
                                                   input logic mf);
    frame_start = '0;
    frame_start[POS_W-1:BIT_W+CH_W] = mf ? MF_START : pos_fr(p);
  endfunction : frame_start

  function automatic logic [DW-1:0] be_merge(input logic [DW-1:0] old_v,
                                             input logic [DW-1:0] new_v,
                                             input logic [BE_W-1:0] be);
    be_merge = old_v;
    for (int i = 0; i < BE_W; i++)
      if (be[i])
        be_merge[i*BYTE_W +: BYTE_W] = new_v[i*BYTE_W +: BYTE_W];
  endfunction : be_merge
endpackage : e1t_pkg

// >>> logic/e1t_mem_if.sv
// Port bundle between the transmit core and its elastic store memory
`timescale 1ns/1ns
interface e1t_mem_if;
  import e1t_pkg::*;
  logic             wr_en;
  logic [ES_AW-1:0] wr_addr;
  logic             wr_data;
  logic [ES_AW-1:0] rd_addr;
  logic             rd_data;
  modport core  (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
  modport store (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface : e1t_mem_if

// >>> logic/e1t_pin_sync.sv
// Two-flop pin synchroniser with registered edge pulses
`timescale 1ns/1ns
module e1t_pin_sync (
  // Clock, reset and enable
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  input  wire logic clk_en_in,
  // Pin and results
  input  wire logic pin_in,
  output logic      level_out,
  output logic      rise_out,
  output logic      fall_out
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic lvl;
    logic rise;
    logic fall;
  } e1t_sync_t;

  e1t_sync_t st_ff;
  e1t_sync_t nxt_st;

  // First stage feeds only the second stage
  always_comb
  begin
    nxt_st.s1   = pin_in;
    nxt_st.s2   = st_ff.s1;
    nxt_st.lvl  = st_ff.s2;
    nxt_st.rise = st_ff.s2 & ~st_ff.lvl;
    nxt_st.fall = ~st_ff.s2 & st_ff.lvl;
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      st_ff <= '0;
    else if (clk_en_in)
      st_ff <= nxt_st;
  end

  assign level_out = st_ff.lvl;
  assign rise_out  = st_ff.rise;
  assign fall_out  = st_ff.fall;
endmodule : e1t_pin_sync

// >>> logic/e1t_es_mem.sv
// Two-frame elastic store bit memory with registered read
`timescale 1ns/1ns
module e1t_es_mem
  import e1t_pkg::*;
(
  // Clock, reset and enable
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  input  wire logic clk_en_in,
  // Memory port
  e1t_mem_if.store  mem_io
);
  typedef struct packed {
    logic [ES_DEPTH-1:0] bits;
    logic                rd;
  } e1t_mem_t;

  e1t_mem_t st_ff;
  e1t_mem_t nxt_st;

  always_comb
  begin
    nxt_st = st_ff;
    if (mem_io.wr_en)
      nxt_st.bits[mem_io.wr_addr] = mem_io.wr_data;
    nxt_st.rd = st_ff.bits[mem_io.rd_addr];
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      st_ff <= '0;
    else if (clk_en_in)
      st_ff <= nxt_st;
  end

  assign mem_io.rd_data = st_ff.rd;
endmodule : e1t_es_mem

// >>> logic/e1t_tx_pins.sv
// Transmit-side pin interface: store path, formatter, sync and line sampling
`timescale 1ns/1ns
module e1t_tx_pins
  import e1t_pkg::*;
(
  // Clock, reset and enable
  input  wire logic             clk_in,
  input  wire logic             arst_n_in,
  input  wire logic             clk_en_in,
  // Register bus
  input  wire logic [AV_AW-1:0] avs_address_in,
  input  wire logic             avs_read_in,
  input  wire logic             avs_write_in,
  input  wire logic [DW-1:0]    avs_writedata_in,
  input  wire logic [BE_W-1:0]  avs_byteenable_in,
  output logic [DW-1:0]         avs_readdata_out,
  output logic                  avs_waitrequest_out,
  // Backplane side
  input  wire logic             tx_primary_clock_in,
  input  wire logic             tx_backplane_clock_in,
  input  wire logic             tx_serial_in,
  input  wire logic             tx_signaling_in,
  input  wire logic             tx_link_in,
  input  wire logic             tx_backplane_boundary_in,
  input  wire logic             tx_boundary_pulse_in,
  input  wire logic             tx_formatter_in,
  output logic                  tx_boundary_pulse_out,
  output logic                  tx_boundary_pulse_oe_out,
  output logic                  tx_channel_clock_out,
  output logic                  tx_channel_block_out,
  output logic                  tx_link_demand_clock_out,
  output logic                  tx_elastic_out,
  // Line side
  input  wire logic             line_pos_in,
  input  wire logic             line_neg_in,
  input  wire logic             line_tx_clock_in,
  input  wire logic             line_iface_connect_in,
  output logic                  fmt_pos_out,
  output logic                  fmt_neg_out,
  output logic                  fmt_clock_out
);
  typedef struct packed {
    e1t_bus_t         bus;
    logic             waitreq;
    logic [DW-1:0]    rdata;
    logic [DW-1:0]    ctrl;
    logic [NCH-1:0]   chblk_sel;
    logic [POS_W-1:0] bpos;
    logic [POS_W-1:0] fpos;
    logic             sdat;
    logic             sig;
    logic             eso;
    logic             fdat;
    logic             pos;
    logic             neg;
    logic             ami_neg;
    logic             fmt_clk;
    logic             chclk;
    logic             chblk;
    logic             link_clk;
    logic             sync_o;
    logic             sync_oe;
    logic [LSH_W-1:0] lpos;
    logic [LSH_W-1:0] lneg;
  } e1t_state_t;

  e1t_state_t      st_ff;
  e1t_state_t      nxt_st;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_lvl;
  logic [NPIN-1:0] pin_rise;
  logic [NPIN-1:0] pin_fall;
  logic            es_on;
  logic            mf_sel;
  logic            b_rise;
  logic            b_fall;
  logic            p_rise;
  logic            p_fall;
  logic            l_fall;
  logic            l_pos;
  logic            l_neg;
  logic [SA_N-1:0] sa_sel;

  e1t_mem_if es_if ();

  assign pin_raw[P_PCLK]  = tx_primary_clock_in;
  assign pin_raw[P_BCLK]  = tx_backplane_clock_in;
  assign pin_raw[P_LCLK]  = line_tx_clock_in;
  assign pin_raw[P_SER]   = tx_serial_in;
  assign pin_raw[P_SIG]   = tx_signaling_in;
  assign pin_raw[P_LINK]  = tx_link_in;
  assign pin_raw[P_FDAT]  = tx_formatter_in;
  assign pin_raw[P_LPOS]  = line_pos_in;
  assign pin_raw[P_LNEG]  = line_neg_in;
  assign pin_raw[P_SYNC]  = tx_boundary_pulse_in;
  assign pin_raw[P_BSYNC] = tx_backplane_boundary_in;
  assign pin_raw[P_CONN]  = line_iface_connect_in;

  // Clocks and data share one latency, so data lines up with clock edges
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++)
    begin : g_pin
      e1t_pin_sync u_sync (
        .clk_in    (clk_in),
        .arst_n_in (arst_n_in),
        .clk_en_in (clk_en_in),
        .pin_in    (pin_raw[gi]),
        .level_out (pin_lvl[gi]),
        .rise_out  (pin_rise[gi]),
        .fall_out  (pin_fall[gi])
      );
    end
  endgenerate

  e1t_es_mem u_es (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .clk_en_in (clk_en_in),
    .mem_io    (es_if.store)
  );

  assign es_on  = st_ff.ctrl[C_ES];
  assign mf_sel = st_ff.ctrl[C_SYNC_MF];
  assign sa_sel = st_ff.ctrl[C_SA +: SA_N];
  assign p_rise = pin_rise[P_PCLK];
  assign p_fall = pin_fall[P_PCLK];
  // Backplane clock is only trusted with the store on
  assign b_rise = es_on ? pin_rise[P_BCLK] : p_rise;
  assign b_fall = es_on ? pin_fall[P_BCLK] : p_fall;
  // Loopback uses the internal formatter clock and data
  assign l_fall = pin_lvl[P_CONN] ? p_fall : pin_fall[P_LCLK];
  assign l_pos  = pin_lvl[P_CONN] ? st_ff.pos : pin_lvl[P_LPOS];
  assign l_neg  = pin_lvl[P_CONN] ? st_ff.neg : pin_lvl[P_LNEG];

  // Store written on backplane timing, read on primary timing
  assign es_if.wr_en   = b_fall & es_on;
  assign es_if.wr_addr = st_ff.bpos[ES_AW-1:0];
  assign es_if.wr_data = pin_lvl[P_SER];
  assign es_if.rd_addr = st_ff.fpos[ES_AW-1:0];

  always_comb
  begin
    nxt_st = st_ff;
    // Register bus slave
    case (st_ff.bus)
      BUS_IDLE:
      begin
        if (avs_read_in || avs_write_in)
        begin
          nxt_st.bus     = BUS_ACK;
          nxt_st.waitreq = 1'b0;
          case (avs_address_in)
            OFS_CTRL:  nxt_st.rdata = st_ff.ctrl;
            OFS_CHBLK: nxt_st.rdata = st_ff.chblk_sel;
            OFS_STAT:  nxt_st.rdata = DW'({st_ff.bpos, st_ff.fpos});
            OFS_LINE:  nxt_st.rdata = DW'({st_ff.lneg, st_ff.lpos});
            default:   nxt_st.rdata = '0;
          endcase
        end
      end
      BUS_ACK:
      begin
        nxt_st.bus     = BUS_IDLE;
        nxt_st.waitreq = 1'b1;
        if (avs_write_in && avs_address_in == OFS_CTRL)
          nxt_st.ctrl = be_merge(st_ff.ctrl, avs_writedata_in, avs_byteenable_in);
        if (avs_write_in && avs_address_in == OFS_CHBLK)
          nxt_st.chblk_sel = be_merge(st_ff.chblk_sel, avs_writedata_in,
                                      avs_byteenable_in);
      end
      default:
      begin
        nxt_st.bus     = BUS_IDLE;
        nxt_st.waitreq = 1'b1;
      end
    endcase

    // Backplane-side sampling
    if (b_fall)
    begin
      nxt_st.sdat = pin_lvl[P_SER];
      if (st_ff.ctrl[C_SIG])
        nxt_st.sig = pin_lvl[P_SIG];
    end
    if (b_rise && es_on)
      nxt_st.bpos = st_ff.bpos + 1'b1;
    if (es_on && pin_rise[P_BSYNC])
      nxt_st.bpos = frame_start(st_ff.bpos, mf_sel);

    // Bit 0 of a slot is its MSB; slot 0 follows the frame start
    if (p_rise)
      nxt_st.fpos = st_ff.fpos + 1'b1;
    if (st_ff.ctrl[C_SYNC_IN] && pin_rise[P_SYNC])
      nxt_st.fpos = frame_start(st_ff.fpos, mf_sel);
    if (!es_on)
      nxt_st.bpos = nxt_st.fpos;

    if (b_rise)
    begin
      nxt_st.chclk = pos_bit(nxt_st.bpos) == LSB_BIT;
      nxt_st.chblk = st_ff.chblk_sel[pos_ch(nxt_st.bpos)];
    end

    // All primary-timed outputs move on the rising edge only
    if (p_rise)
    begin
      nxt_st.eso      = es_on ? es_if.rd_data : st_ff.sdat;
      nxt_st.link_clk = st_ff.ctrl[C_LINK] && sa_hit(nxt_st.fpos, sa_sel);
      nxt_st.sync_o   = pos_bit(nxt_st.fpos) == MSB_BIT && pos_ch(nxt_st.fpos) == FAS_SLOT
                        && (!mf_sel || pos_fr(nxt_st.fpos) == MF_START);
      if (st_ff.ctrl[C_NRZ])
      begin
        nxt_st.pos = st_ff.fdat;
        nxt_st.neg = 1'b0;
      end
      else
      begin
        nxt_st.pos = st_ff.fdat & ~st_ff.ami_neg;
        nxt_st.neg = st_ff.fdat & st_ff.ami_neg;
        if (st_ff.fdat)
          nxt_st.ami_neg = ~st_ff.ami_neg;
      end
    end

    // Formatter input and overhead insertion on the falling edge
    if (p_fall)
    begin
      nxt_st.fdat = pin_lvl[P_FDAT];
      if (pos_ch(st_ff.fpos) == FAS_SLOT && !st_ff.fpos[BIT_W+CH_W])
        nxt_st.fdat = FAS_BYTE[LSB_BIT - pos_bit(st_ff.fpos)];
      if (st_ff.ctrl[C_LINK] && sa_hit(st_ff.fpos, sa_sel))
        nxt_st.fdat = pin_lvl[P_LINK];
      if (st_ff.ctrl[C_SIG] && pos_ch(st_ff.fpos) == SIG_SLOT)
        nxt_st.fdat = st_ff.sig;
    end

    nxt_st.fmt_clk = pin_lvl[P_PCLK];
    nxt_st.sync_oe = ~st_ff.ctrl[C_SYNC_IN];

    if (l_fall)
    begin
      nxt_st.lpos = {st_ff.lpos[LSH_W-2:0], l_pos};
      nxt_st.lneg = {st_ff.lneg[LSH_W-2:0], l_neg};
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      st_ff           <= '0;
      st_ff.bus       <= BUS_IDLE;
      st_ff.waitreq   <= 1'b1;
      st_ff.ctrl      <= CTRL_RST;
      st_ff.chblk_sel <= CHBLK_RST;
      st_ff.sync_oe   <= 1'b1;
    end
    else if (clk_en_in)
      st_ff <= nxt_st;
  end

  assign avs_readdata_out         = st_ff.rdata;
  assign avs_waitrequest_out      = st_ff.waitreq;
  assign tx_boundary_pulse_out    = st_ff.sync_o;
  assign tx_boundary_pulse_oe_out = st_ff.sync_oe;
  assign tx_channel_clock_out     = st_ff.chclk;
  assign tx_channel_block_out     = st_ff.chblk;
  assign tx_link_demand_clock_out = st_ff.link_clk;
  assign tx_elastic_out           = st_ff.eso;
  assign fmt_pos_out              = st_ff.pos;
  assign fmt_neg_out              = st_ff.neg;
  assign fmt_clock_out            = st_ff.fmt_clk;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  chclk_lsb_a: assert property ($rose(tx_channel_clock_out) |->
    pos_bit(st_ff.bpos) == LSB_BIT) else $error("channel clock off the LSB");
  eso_edge_a: assert property ($changed(tx_elastic_out) |->
    $past(p_rise)) else $error("elastic output moved without primary rise");
  fmt_edge_a: assert property (($changed(fmt_pos_out) || $changed(fmt_neg_out))
    |-> $rose(fmt_clock_out)) else $error("formatter output moved off clock rise");
  ami_excl_a: assert property (!(fmt_pos_out && fmt_neg_out))
    else $error("both formatter outputs high");
  nrz_pos_a: assert property ($past(p_rise) && $past(st_ff.ctrl[C_NRZ]) |->
    !fmt_neg_out && fmt_pos_out == $past(st_ff.fdat)) else $error("NRZ output wrong");
  sync_pulse_a: assert property ($rose(tx_boundary_pulse_out) |->
    pos_bit(st_ff.fpos) == MSB_BIT && pos_ch(st_ff.fpos) == FAS_SLOT)
    else $error("sync pulse off frame start");
  sync_dir_a: assert property (tx_boundary_pulse_oe_out ==
    !$past(st_ff.ctrl[C_SYNC_IN])) else $error("sync pin direction wrong");
  link_ins_a: assert property (p_fall && st_ff.ctrl[C_LINK] &&
    sa_hit(st_ff.fpos, sa_sel) |=> st_ff.fdat == $past(pin_lvl[P_LINK]))
    else $error("link bit not inserted");
  sig_ins_a: assert property (p_fall && st_ff.ctrl[C_SIG] &&
    pos_ch(st_ff.fpos) == SIG_SLOT |=> st_ff.fdat == $past(st_ff.sig))
    else $error("signaling bit not inserted");
  line_loop_a: assert property (pin_lvl[P_CONN] && p_fall ##1 clk_en_in |->
    st_ff.lpos[0] == $past(st_ff.pos)) else $error("loopback sample wrong");
  bus_ack_a: assert property (!avs_waitrequest_out ##1 clk_en_in |->
    avs_waitrequest_out) else $error("waitrequest low too long");
endmodule : e1t_tx_pins

// >>> dv/e1t_bp_model.sv
// Backplane logic and line interface model facing the transmit pins
`timescale 1ns/1ns
module e1t_bp_model (
  // Controls from the bench
  input  wire logic es_on_in,
  input  wire logic ser_lvl_in,
  input  wire logic line_ext_in,
  input  wire logic line_lvl_in,
  // From the device
  input  wire logic demand_in,
  input  wire logic elastic_in,
  input  wire logic fpos_in,
  input  wire logic fneg_in,
  input  wire logic fclk_in,
  // To the device
  output logic      pclk_out,
  output logic      bclk_out,
  output logic      ser_out,
  output logic      sig_out,
  output logic      link_out,
  output logic      bbound_out,
  output logic      fdat_out,
  output logic      lpos_out,
  output logic      lneg_out,
  output logic      lclk_out
);
  logic link_q;

  // Odd start offset keeps the pin clock edges 7 ns off the core clock edges
  initial
  begin
    {pclk_out, ser_out, sig_out, link_out, link_q} = '0;
    #7;
    forever #160 pclk_out = ~pclk_out;
  end

  // Only clocked while the store is in use
  initial
  begin
    bclk_out = 1'b0;
    forever
    begin
      if (es_on_in)
        #244 bclk_out = ~bclk_out;
      else
      begin
        bclk_out = 1'b0;
        @(es_on_in);
      end
    end
  end

  // Data moves after the rise so the falling-edge samplers see it settled
  always @(posedge pclk_out)
  begin
    #20;
    ser_out = ser_lvl_in;
    sig_out = ser_lvl_in;
    if (demand_in === 1'b1)
      link_q = ~link_q;
    link_out = link_q;
  end

  assign bbound_out = 1'b0;
  assign fdat_out   = elastic_in;
  assign lpos_out   = line_ext_in ? line_lvl_in : fpos_in;
  assign lneg_out   = line_ext_in ? line_lvl_in : fneg_in;
  assign lclk_out   = line_ext_in ? pclk_out : fclk_in;
endmodule : e1t_bp_model

// >>> dv/tb.sv
// Self-checking bench for the E1 transmit pin interface
`timescale 1ns/1ns
module tb;
  import e1t_pkg::*;
  logic             clk_in = 1'b0;
  logic             arst_n = 1'b0;
  logic [AV_AW-1:0] adr    = '0;
  logic             rd_req = 1'b0;
  logic             wr_req = 1'b0;
  logic [DW-1:0]    wdat   = '0;
  logic [BE_W-1:0]  be     = '0;
  logic [DW-1:0]    rdat, rd;
  logic             wait_rq, sync_o, sync_oe, chclk, chblk, dclk, eso, fpos, fneg, fclk;
  logic             pclk, bclk, ser, sig, link, bbound, fdat, lpos, lneg, lclk;
  logic             sync_drv = 1'b0;
  logic             conn     = 1'b0;
  logic             clk_en   = 1'b1;
  logic             es_on    = 1'b0;
  logic             ser_lvl  = 1'b0;
  logic             line_ext = 1'b0;
  logic             line_lvl = 1'b0;
  int               num_errors = 0;
  int               n_compared = 0;
  wire              sync_pin;
  localparam logic [DW-1:0] PAT = 32'hA5C3_0F69;

  assign sync_pin = (sync_oe === 1'b1) ? sync_o : sync_drv;
  always #20 clk_in = ~clk_in;

  e1t_tx_pins dut (
    .clk_in(clk_in), .arst_n_in(arst_n), .clk_en_in(clk_en),
    .avs_address_in(adr), .avs_read_in(rd_req), .avs_write_in(wr_req),
    .avs_writedata_in(wdat), .avs_byteenable_in(be), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wait_rq), .tx_primary_clock_in(pclk), .tx_backplane_clock_in(bclk),
    .tx_serial_in(ser), .tx_signaling_in(sig), .tx_link_in(link),
    .tx_backplane_boundary_in(bbound), .tx_boundary_pulse_in(sync_pin),
    .tx_formatter_in(fdat), .tx_boundary_pulse_out(sync_o), .tx_boundary_pulse_oe_out(sync_oe),
    .tx_channel_clock_out(chclk), .tx_channel_block_out(chblk),
    .tx_link_demand_clock_out(dclk), .tx_elastic_out(eso), .line_pos_in(lpos),
    .line_neg_in(lneg), .line_tx_clock_in(lclk), .line_iface_connect_in(conn),
    .fmt_pos_out(fpos), .fmt_neg_out(fneg), .fmt_clock_out(fclk)
  );

  e1t_bp_model partner (
    .es_on_in(es_on), .ser_lvl_in(ser_lvl), .line_ext_in(line_ext), .line_lvl_in(line_lvl),
    .demand_in(dclk), .elastic_in(eso), .fpos_in(fpos), .fneg_in(fneg), .fclk_in(fclk),
    .pclk_out(pclk), .bclk_out(bclk), .ser_out(ser), .sig_out(sig), .link_out(link),
    .bbound_out(bbound), .fdat_out(fdat), .lpos_out(lpos), .lneg_out(lneg), .lclk_out(lclk)
  );

  task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Holds the request until the edge that sees waitrequest low
  task automatic bus(input logic wr, input logic [AV_AW-1:0] a, input logic [DW-1:0] d,
                     input logic [BE_W-1:0] b);
    int n;
    n = 0;
    @(posedge clk_in);
    adr <= a;
    wdat <= d;
    be <= b;
    rd_req <= !wr;
    wr_req <= wr;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (wait_rq !== 1'b0 && n < 50);
    if (wait_rq !== 1'b0)
      num_errors++;
    rd = rdat;
    rd_req <= 1'b0;
    wr_req <= 1'b0;
  endtask : bus

  function automatic logic pick(input int k);
    case (k)
      0: pick = chclk;
      1: pick = sync_o;
      default: pick = fclk;
    endcase
  endfunction : pick

  task automatic rise(input int k, output int n);
    logic p;
    n = 0;
    do
    begin
      p = pick(k);
      @(posedge clk_in);
      #1;
      n++;
    end
    while (!(p === 1'b0 && pick(k) === 1'b1) && n < 40000);
  endtask : rise

  task automatic t_regs;
    logic hold;
    bus(1'b0, OFS_CTRL, '0, '0);
    chk(rd, CTRL_RST);
    bus(1'b0, OFS_CHBLK, '0, '0);
    chk(rd, CHBLK_RST);
    bus(1'b1, OFS_CTRL, 32'hFFFF_1F34, 4'h1);
    bus(1'b1, 4'h2, 32'hFFFF_FFFF, 4'hF);
    bus(1'b0, 4'h2, '0, '0);
    chk(rd, 32'h0000_0000);
    bus(1'b0, OFS_CTRL, '0, '0);
    chk(rd, 32'h0000_0034);
    bus(1'b1, OFS_CTRL, 32'h0000_0000, 4'hF);
    // Frozen core must hold its clock copy longer than a primary period
    clk_en <= 1'b0;
    @(posedge clk_in);
    hold = fclk;
    repeat (12) @(posedge clk_in);
    chk(DW'(fclk), DW'(hold));
    clk_en <= 1'b1;
  endtask : t_regs

  task automatic t_chan;
    int n;
    bus(1'b1, OFS_CHBLK, PAT, 4'hF);
    rise(1, n);
    rise(1, n);
    chk(DW'(n), 32'd2048);
    for (int k = 0; k < NCH; k++)
    begin
      rise(0, n);
      chk(DW'(n), (k == 0) ? 32'd56 : 32'd64);
      chk(DW'(chblk), DW'(PAT[k]));
    end
  endtask : t_chan

  task automatic t_mf;
    int n;
    bus(1'b1, OFS_CTRL, 32'h0000_0003, 4'hF);
    repeat (4) @(posedge clk_in);
    chk(DW'(sync_oe), 32'h0);
    sync_drv <= 1'b1;
    repeat (16) @(posedge clk_in);
    sync_drv <= 1'b0;
    bus(1'b0, OFS_STAT, '0, '0);
    chk(DW'(rd[11:3]), 32'h0);
    bus(1'b1, OFS_CTRL, 32'h0000_0002, 4'hF);
    rise(1, n);
    chk(DW'(n > 32700 && n < 32780), 32'h1);
    chk(DW'(sync_oe), 32'h1);
  endtask : t_mf

  // Zero data in NRZ: only the alignment byte shows, MSB first
  task automatic t_fmt;
    int n;
    int np;
    int nn;
    int both;
    logic [7:0] sh;
    sh = '0;
    np = 0;
    bus(1'b1, OFS_CTRL, 32'h0000_0004, 4'hF);
    repeat (520)
    begin
      rise(2, n);
      sh = {sh[6:0], fpos};
      np += int'(sh === FAS_BYTE);
    end
    chk(DW'(np > 0), 32'h1);
    line_ext <= 1'b1;
    line_lvl <= 1'b1;
    bus(1'b1, OFS_CTRL, 32'h0000_0000, 4'hF);
    repeat (160) @(posedge clk_in);
    bus(1'b0, OFS_LINE, '0, '0);
    chk(rd, 32'h0000_FFFF);
    conn <= 1'b1;
    repeat (160) @(posedge clk_in);
    bus(1'b0, OFS_LINE, '0, '0);
    chk(DW'(rd[15:0] !== 16'hFFFF), 32'h1);
    conn <= 1'b0;
    line_ext <= 1'b0;
    ser_lvl <= 1'b1;
    np = 0;
    nn = 0;
    both = 0;
    repeat (1024)
    begin
      rise(2, n);
      np += int'(fpos === 1'b1);
      nn += int'(fneg === 1'b1);
      both += int'(fpos === 1'b1 && fneg === 1'b1);
    end
    chk(DW'(both), 32'h0);
    chk(DW'(np - nn <= 1 && nn - np <= 1 && np + nn >= 980), 32'h1);
  endtask : t_fmt

  task automatic t_link_es;
    int n;
    bus(1'b1, OFS_CTRL, 32'h0000_0510, 4'hF);
    repeat (8) @(posedge clk_in);
    n = 0;
    repeat (4096)
    begin
      @(posedge clk_in);
      #1;
      n += int'(dclk === 1'b1);
    end
    chk(DW'(n), 32'd16);
    es_on <= 1'b1;
    bus(1'b1, OFS_CTRL, 32'h0000_0008, 4'hF);
    rise(0, n);
    rise(0, n);
    chk(DW'(n >= 96 && n <= 99), 32'h1);
    bus(1'b1, OFS_CTRL, 32'h0000_0000, 4'hF);
    es_on <= 1'b0;
  endtask : t_link_es

  task automatic wrap_up;
    $display("compared=%0d mismatches=%0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up

  initial
  begin
    repeat (20) @(posedge clk_in);
    chk({28'h0, wait_rq, sync_oe, chclk, fclk}, 32'hC);
    arst_n <= 1'b1;
    t_regs();
    t_chan();
    t_mf();
    t_fmt();
    t_link_es();
    wrap_up();
  end

  // Run needs about 2.2 ms of simulated time
  initial
  begin
    #3_800_000;
    num_errors++;
    wrap_up();
  end
endmodule : tb
